// ### shared/lcd_drv_map.svh
// register map, field positions, reset values and timing counts
//------------------------------------------------------------------------------
// Notes on behaviour
// - upper select bits: bit 0 is SEG40 up to bit 7 SEG47; 1 drives, reset 0
// - bias kind bit picks resistor or capacitor bias; capacitor starts pump
// - supply select 0 takes external supply pin, 1 takes internal pump
// - two-bit pump level picks one of four pump output voltages
// - capacitor bias source 00 uses external pins, other codes internal
// - source codes 01, 10, 11 pick 1.08V reference, 3V regulator, main supply
// - quarter duty: four common lines, frame split into four slots
// - waveform bit picks Type A or Type B; Type B has lower frequency
// - common and segment waveforms built by hardware with zero net DC
// - display enable 0 stops all common and segment driving
// - display enable is cleared at power-on
// - resistor bias uses one-third bias: ground, 1/3, 2/3 and full levels
// - two-bit bias current field picks resistor bias current
// - drive clock is sub clock divided by eight, nominal 4kHz
// - memory bits 0 to 3 of each byte are one pixel each (bit = common), 1 on, 0 off, read continuously
// - enable acts in Normal, Slow and Idle; Sleep always blanks display
// - bias kind bit: 0 resistor, 1 capacitor, reset 0
//------------------------------------------------------------------------------
`ifndef LCD_DRV_MAP_SVH
`define LCD_DRV_MAP_SVH

//------------------------------------------------------------------------------
// register offsets
//------------------------------------------------------------------------------
`define LCD_ADDR_PUMP_CTRL 8'h00
`define LCD_ADDR_DISP_CTRL 8'h01
`define LCD_ADDR_SEG_SEL_HI 8'h02
`define LCD_ADDR_STATUS 8'h03
`define LCD_ADDR_MEM_BASE 8'h10
`define LCD_ADDR_MEM_LAST 8'h17

//------------------------------------------------------------------------------
// field positions
//------------------------------------------------------------------------------
`define LCD_PUMP_SUPPLY_BIT 3
`define LCD_PUMP_LEVEL_LO 0
`define LCD_DISP_TYPE_BIT 7
`define LCD_DISP_KIND_BIT 6
`define LCD_DISP_SRC_LO 4
`define LCD_DISP_CUR_LO 1
`define LCD_DISP_EN_BIT 0

//------------------------------------------------------------------------------
// reset values
//------------------------------------------------------------------------------
`define LCD_RST_PUMP_CTRL 8'h00
`define LCD_RST_DISP_CTRL 8'h00
`define LCD_RST_SEG_SEL_HI 8'h00

//------------------------------------------------------------------------------
// timing
//------------------------------------------------------------------------------
`define LCD_CLK_HZ 25000000
`define LCD_SUB_HZ 32000
`define LCD_SUB_CYCLES (`LCD_CLK_HZ / `LCD_SUB_HZ)
`define LCD_SUB_LAST 10'(`LCD_SUB_CYCLES - 1)
`define LCD_DRV_DIV 8
`define LCD_DRV_LAST 3'(`LCD_DRV_DIV - 1)
`define LCD_SEG_COUNT 8
`define LCD_COM_COUNT 4

`endif

// ### shared/lcd_drv_pkg.sv
// types shared by the segment LCD driver files
package lcd_drv_pkg;

	// drive level of a common or segment line under one-third bias
	typedef enum logic [1:0] {
		LVL_GROUND = 2'b00,
		LVL_THIRD = 2'b01,
		LVL_TWO_THIRDS = 2'b10,
		LVL_FULL = 2'b11
	} level_type;

	// waveform generation style
	typedef enum logic {
		WAVE_A = 1'b0,
		WAVE_B = 1'b1
	} wave_type;

endpackage

// ### rtl/lcd_frame_timer.sv
// drive clock divider and four-slot frame sequencer
`include "lcd_drv_map.svh"

module lcd_frame_timer
	import lcd_drv_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// control
	input wire logic i_run,
	input wire wave_type i_wave,
	// frame position
	output logic [1:0] o_slot,
	output logic o_phase
);

	logic [9:0] sub_cnt_q;
	logic [2:0] div_cnt_q;
	logic sub_tick;
	logic drv_tick;

	assign sub_tick = (sub_cnt_q == `LCD_SUB_LAST);
	assign drv_tick = sub_tick && (div_cnt_q == `LCD_DRV_LAST);

	// sub clock enable, then divide by eight for the drive clock
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sub_cnt_q <= 10'h000;
			div_cnt_q <= 3'h0;
		end else if (!i_run) begin
			sub_cnt_q <= 10'h000;
			div_cnt_q <= 3'h0;
		end else begin
			sub_cnt_q <= sub_tick ? 10'h000 : sub_cnt_q + 10'h001;
			if (sub_tick) begin
				div_cnt_q <= div_cnt_q + 3'h1;
			end
		end
	end

	// type A flips polarity every tick, two ticks a slot; type B one tick a
	// slot and flips polarity once a frame, so it flips at a quarter of the rate
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_slot <= 2'h0;
			o_phase <= 1'b0;
		end else if (!i_run) begin
			o_slot <= 2'h0;
			o_phase <= 1'b0;
		end else if (drv_tick) begin
			if (i_wave == WAVE_A) begin
				o_phase <= ~o_phase;
				if (o_phase) begin
					o_slot <= o_slot + 2'h1;
				end
			end else begin
				o_slot <= o_slot + 2'h1;
				if (o_slot == 2'h3) begin
					o_phase <= ~o_phase;
				end
			end
		end
	end

endmodule // lcd_frame_timer

// ### rtl/lcd_segment_driver_control.sv
// segment LCD driver: control registers, display memory and waveforms
`include "lcd_drv_map.svh"

module lcd_segment_driver_control
	import lcd_drv_pkg::*;
(
	// clock and reset
	input wire logic I_CLOCK,
	input wire logic I_RST,
	// register port
	input wire logic [7:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [7:0] O_RDATA,
	// operating mode
	input wire logic I_SLEEP,
	// common lines
	output logic [7:0] O_COM_LEVEL,
	output logic [3:0] O_COM_DRIVE,
	// segment lines SEG40 to SEG47
	output logic [15:0] O_SEG_LEVEL,
	output logic [7:0] O_SEG_DRIVE,
	// bias and supply controls
	output logic O_CAP_BIAS,
	output logic O_RES_BIAS_ON,
	output logic O_PUMP_ON,
	output logic O_SUPPLY_FROM_PUMP,
	output logic [1:0] O_PUMP_LEVEL,
	output logic O_BIAS_FROM_PINS,
	output logic [2:0] O_INT_SOURCE,
	output logic [1:0] O_BIAS_CURRENT
);

	//--------------------------------------------------------------------------
	// control registers
	//--------------------------------------------------------------------------
	logic driver_supply_select_q;
	logic [1:0] pump_level_q;
	wave_type wave_q;
	logic bias_kind_select_q;
	logic [1:0] cap_bias_source_q;
	logic [1:0] bias_current_q;
	logic display_enable_q;
	logic [7:0] segment_output_select_high_q;
	logic [7:0] disp_mem [0:`LCD_SEG_COUNT-1];
	localparam logic [7:0] pump_rst = `LCD_RST_PUMP_CTRL;
	localparam logic [7:0] disp_rst = `LCD_RST_DISP_CTRL;

	logic wr_pump;
	logic wr_disp;
	logic wr_sel;
	logic wr_mem;
	logic [2:0] mem_index;

	assign wr_pump = I_WR && (I_ADDR == `LCD_ADDR_PUMP_CTRL);
	assign wr_disp = I_WR && (I_ADDR == `LCD_ADDR_DISP_CTRL);
	assign wr_sel = I_WR && (I_ADDR == `LCD_ADDR_SEG_SEL_HI);
	assign wr_mem = I_WR && (I_ADDR >= `LCD_ADDR_MEM_BASE)
		&& (I_ADDR <= `LCD_ADDR_MEM_LAST);
	assign mem_index = I_ADDR[2:0];

	// pump control: supply source and pump level
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			driver_supply_select_q <= pump_rst[`LCD_PUMP_SUPPLY_BIT];
			pump_level_q <= pump_rst[`LCD_PUMP_LEVEL_LO +: 2];
		end else if (wr_pump) begin
			driver_supply_select_q <= I_WDATA[`LCD_PUMP_SUPPLY_BIT];
			pump_level_q <= I_WDATA[`LCD_PUMP_LEVEL_LO +: 2];
		end
	end

	// display control: waveform, bias kind, source, current, enable
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			wave_q <= wave_type'(disp_rst[`LCD_DISP_TYPE_BIT]);
			bias_kind_select_q <= disp_rst[`LCD_DISP_KIND_BIT];
			cap_bias_source_q <= disp_rst[`LCD_DISP_SRC_LO +: 2];
			bias_current_q <= disp_rst[`LCD_DISP_CUR_LO +: 2];
			display_enable_q <= disp_rst[`LCD_DISP_EN_BIT];
		end else if (wr_disp) begin
			wave_q <= wave_type'(I_WDATA[`LCD_DISP_TYPE_BIT]);
			bias_kind_select_q <= I_WDATA[`LCD_DISP_KIND_BIT];
			cap_bias_source_q <= I_WDATA[`LCD_DISP_SRC_LO +: 2];
			bias_current_q <= I_WDATA[`LCD_DISP_CUR_LO +: 2];
			display_enable_q <= I_WDATA[`LCD_DISP_EN_BIT];
		end
	end

	// upper segment output select
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			segment_output_select_high_q <= `LCD_RST_SEG_SEL_HI;
		end else if (wr_sel) begin
			segment_output_select_high_q <= I_WDATA;
		end
	end

	// display memory: no reset, contents are undefined until written
	always_ff @(posedge I_CLOCK) begin
		if (wr_mem) begin
			disp_mem[mem_index] <= I_WDATA;
		end
	end

	//--------------------------------------------------------------------------
	// frame sequencing
	//--------------------------------------------------------------------------
	logic drive_active;
	logic [1:0] slot;
	logic phase;

	// sleep always blanks, whatever the enable bit says
	assign drive_active = display_enable_q && !I_SLEEP;

	lcd_frame_timer u_timer (
		.i_clk(I_CLOCK),
		.i_rst(I_RST),
		.i_run(drive_active),
		.i_wave(wave_q),
		.o_slot(slot),
		.o_phase(phase)
	);

	//--------------------------------------------------------------------------
	// register read
	//--------------------------------------------------------------------------
	logic [7:0] rdata_d;
	logic [7:0] rdata_q;

	always_comb begin
		rdata_d = 8'h00;
		if (I_RD) begin
			if (I_ADDR == `LCD_ADDR_PUMP_CTRL) begin
				rdata_d[`LCD_PUMP_SUPPLY_BIT] = driver_supply_select_q;
				rdata_d[`LCD_PUMP_LEVEL_LO +: 2] = pump_level_q;
			end else if (I_ADDR == `LCD_ADDR_DISP_CTRL) begin
				rdata_d[`LCD_DISP_TYPE_BIT] = wave_q;
				rdata_d[`LCD_DISP_KIND_BIT] = bias_kind_select_q;
				rdata_d[`LCD_DISP_SRC_LO +: 2] = cap_bias_source_q;
				rdata_d[`LCD_DISP_CUR_LO +: 2] = bias_current_q;
				rdata_d[`LCD_DISP_EN_BIT] = display_enable_q;
			end else if (I_ADDR == `LCD_ADDR_SEG_SEL_HI) begin
				rdata_d = segment_output_select_high_q;
			end else if (I_ADDR == `LCD_ADDR_STATUS) begin
				rdata_d[3] = drive_active;
				rdata_d[2] = phase;
				rdata_d[1:0] = slot;
			end else if ((I_ADDR >= `LCD_ADDR_MEM_BASE)
					&& (I_ADDR <= `LCD_ADDR_MEM_LAST)) begin
				rdata_d = disp_mem[mem_index];
			end
		end
	end

	// read data stands only in the cycle after the read strobe
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign O_RDATA = rdata_q;

	//--------------------------------------------------------------------------
	// waveform levels
	//--------------------------------------------------------------------------
	// phase 0: selected common full, others 1/3; pixel on ground, off 2/3
	// phase 1: selected common ground, others 2/3; pixel on full, off 1/3
	// every level pair mirrors across the two phases, so net DC is zero
	logic [7:0] com_level_d;
	logic [3:0] com_drive_d;
	logic [15:0] seg_level_d;
	logic [7:0] seg_drive_d;

	genvar gc;
	generate
		for (gc = 0; gc < `LCD_COM_COUNT; gc++) begin : g_com
			level_type lvl;
			always_comb begin
				if (slot == 2'(gc)) begin
					lvl = phase ? LVL_GROUND : LVL_FULL;
				end else begin
					lvl = phase ? LVL_TWO_THIRDS : LVL_THIRD;
				end
			end
			assign com_level_d[2*gc +: 2] = drive_active ? lvl : LVL_GROUND;
			assign com_drive_d[gc] = drive_active;
		end
	endgenerate

	genvar gs;
	generate
		for (gs = 0; gs < `LCD_SEG_COUNT; gs++) begin : g_seg
			logic pixel_on;
			logic seg_live;
			level_type lvl;
			assign pixel_on = disp_mem[gs][slot];
			assign seg_live = drive_active
				&& segment_output_select_high_q[gs];
			always_comb begin
				if (pixel_on) begin
					lvl = phase ? LVL_FULL : LVL_GROUND;
				end else begin
					lvl = phase ? LVL_THIRD : LVL_TWO_THIRDS;
				end
			end
			assign seg_level_d[2*gs +: 2] = seg_live ? lvl : LVL_GROUND;
			assign seg_drive_d[gs] = seg_live;
		end
	endgenerate

	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			O_COM_LEVEL <= 8'h00;
			O_COM_DRIVE <= 4'h0;
			O_SEG_LEVEL <= 16'h0000;
			O_SEG_DRIVE <= 8'h00;
		end else begin
			O_COM_LEVEL <= com_level_d;
			O_COM_DRIVE <= com_drive_d;
			O_SEG_LEVEL <= seg_level_d;
			O_SEG_DRIVE <= seg_drive_d;
		end
	end

	//--------------------------------------------------------------------------
	// bias and supply controls
	//--------------------------------------------------------------------------
	logic [2:0] int_source_d;

	always_comb begin
		int_source_d = 3'h0;
		if (bias_kind_select_q) begin
			unique case (cap_bias_source_q)
				2'h0: int_source_d = 3'h0;
				2'h1: int_source_d = 3'h1;
				2'h2: int_source_d = 3'h2;
				2'h3: int_source_d = 3'h4;
			endcase
		end
	end

	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			O_CAP_BIAS <= 1'b0;
			O_RES_BIAS_ON <= 1'b0;
			O_PUMP_ON <= 1'b0;
			O_SUPPLY_FROM_PUMP <= 1'b0;
			O_PUMP_LEVEL <= 2'h0;
			O_BIAS_FROM_PINS <= 1'b0;
			O_INT_SOURCE <= 3'h0;
			O_BIAS_CURRENT <= 2'h0;
		end else begin
			O_CAP_BIAS <= bias_kind_select_q;
			O_RES_BIAS_ON <= drive_active && !bias_kind_select_q;
			// capacitor bias or pump supply both need the pump running
			O_PUMP_ON <= drive_active
				&& (bias_kind_select_q || driver_supply_select_q);
			O_SUPPLY_FROM_PUMP <= driver_supply_select_q;
			O_PUMP_LEVEL <= pump_level_q;
			O_BIAS_FROM_PINS <= bias_kind_select_q
				&& (cap_bias_source_q == 2'h0);
			O_INT_SOURCE <= int_source_d;
			O_BIAS_CURRENT <= bias_current_q;
		end
	end

endmodule // lcd_segment_driver_control

// ### testbench/lcd_drv_sva.sv
// port assertions for the segment LCD driver
module lcd_drv_sva (
	// clock and reset
	input wire logic I_CLOCK,
	input wire logic I_RST,
	// watched ports
	input wire logic I_SLEEP,
	input wire logic [7:0] O_COM_LEVEL,
	input wire logic [3:0] O_COM_DRIVE,
	input wire logic [15:0] O_SEG_LEVEL,
	input wire logic [7:0] O_SEG_DRIVE,
	input wire logic O_CAP_BIAS,
	input wire logic O_RES_BIAS_ON,
	input wire logic O_PUMP_ON,
	input wire logic O_BIAS_FROM_PINS,
	input wire logic [2:0] O_INT_SOURCE
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [12:0] hold_q;
	logic [2:0] sel_n;
	default clocking @(posedge I_CLOCK);
	endclocking
	default disable iff (I_RST);
	// a selected common sits at ground or full: both code bits equal
	always_comb begin
		sel_n = 3'h0;
		for (int j = 0; j < 4; j++)
			if (O_COM_LEVEL[2*j] == O_COM_LEVEL[2*j+1])
				sel_n = sel_n + 3'h1;
	end
	// cycles the common levels have held while driven
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST)
			hold_q <= 13'h0;
		else if (O_COM_DRIVE != 4'hF || $changed(O_COM_LEVEL))
			hold_q <= 13'h0;
		else
			hold_q <= hold_q + 13'h1;
	end
	property p_reset_blank;
		$fell(I_RST) |-> O_COM_DRIVE == 4'h0 && O_SEG_DRIVE == 8'h00;
	endproperty
	a_reset_blank: assert property (p_reset_blank)
		else $error("display driven right after reset");
	property p_sleep_blank;
		I_SLEEP |=> O_COM_DRIVE == 4'h0 && O_SEG_DRIVE == 8'h00 &&
			!O_PUMP_ON && !O_RES_BIAS_ON;
	endproperty
	a_sleep_blank: assert property (p_sleep_blank)
		else $error("display still driven in sleep");
	property p_one_com;
		O_COM_DRIVE == 4'hF |-> sel_n == 3'h1;
	endproperty
	a_one_com: assert property (p_one_com)
		else $error("not exactly one common selected");
	property p_thirds;
		O_COM_DRIVE == 4'hF && O_COM_LEVEL[0] == O_COM_LEVEL[1] |->
			O_COM_LEVEL[7:2] == (O_COM_LEVEL[0] ? 6'h15 : 6'h2A);
	endproperty
	a_thirds: assert property (p_thirds)
		else $error("unselected common level wrong");
	property p_tick_gap;
		O_COM_DRIVE == 4'hF && $past(O_COM_DRIVE) == 4'hF &&
			$changed(O_COM_LEVEL) |-> hold_q == 13'h1867;
	endproperty
	a_tick_gap: assert property (p_tick_gap)
		else $error("common levels changed off the drive tick");
	property p_tick_due;
		O_COM_DRIVE == 4'hF |-> hold_q <= 13'h1867;
	endproperty
	a_tick_due: assert property (p_tick_due)
		else $error("frame stopped advancing");
	property p_cap_pump;
		O_CAP_BIAS && O_COM_DRIVE == 4'hF |-> O_PUMP_ON && !O_RES_BIAS_ON;
	endproperty
	a_cap_pump: assert property (p_cap_pump)
		else $error("capacitor bias without pump");
	property p_res_ladder;
		O_RES_BIAS_ON |-> !O_CAP_BIAS && O_COM_DRIVE == 4'hF;
	endproperty
	a_res_ladder: assert property (p_res_ladder)
		else $error("resistor ladder on when not wanted");
	property p_pin_source;
		O_BIAS_FROM_PINS |-> O_CAP_BIAS && O_INT_SOURCE == 3'h0;
	endproperty
	a_pin_source: assert property (p_pin_source)
		else $error("pin source beside internal source");
	property p_int_source;
		O_INT_SOURCE != 3'h0 |-> O_CAP_BIAS && $onehot(O_INT_SOURCE);
	endproperty
	a_int_source: assert property (p_int_source)
		else $error("internal source code wrong");
	property p_seg_idle;
		!O_SEG_DRIVE[0] |-> O_SEG_LEVEL[1:0] == 2'h0;
	endproperty
	a_seg_idle: assert property (p_seg_idle)
		else $error("unselected segment carries a level");
endmodule // lcd_drv_sva

bind lcd_segment_driver_control lcd_drv_sva i_sva (
	.I_CLOCK(I_CLOCK),
	.I_RST(I_RST),
	.I_SLEEP(I_SLEEP),
	.O_COM_LEVEL(O_COM_LEVEL),
	.O_COM_DRIVE(O_COM_DRIVE),
	.O_SEG_LEVEL(O_SEG_LEVEL),
	.O_SEG_DRIVE(O_SEG_DRIVE),
	.O_CAP_BIAS(O_CAP_BIAS),
	.O_RES_BIAS_ON(O_RES_BIAS_ON),
	.O_PUMP_ON(O_PUMP_ON),
	.O_BIAS_FROM_PINS(O_BIAS_FROM_PINS),
	.O_INT_SOURCE(O_INT_SOURCE)
);

// ### testbench/lcd_panel_model.sv
// glass panel model: which pixels of the selected common see full voltage
module lcd_panel_model (
	// driver lines
	input wire logic [7:0] i_com_level,
	input wire logic [3:0] i_com_drive,
	input wire logic [15:0] i_seg_level,
	input wire logic [7:0] i_seg_drive,
	// lit pixels of the selected common
	output logic [7:0] o_lit
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] sel;
	always_comb begin
		sel = 2'h0;
		for (int j = 0; j < 4; j++)
			if (i_com_level[2*j] == i_com_level[2*j+1])
				sel = 2'(j);
	end
	// the glass answers at once: no clock on this side
	always_comb begin
		for (int i = 0; i < 8; i++)
			o_lit[i] = i_com_drive[sel] && i_seg_drive[i] &&
				i_seg_level[2*i] == i_seg_level[2*i+1] &&
				i_com_level[2*sel+:2] == ~i_seg_level[2*i+:2];
	end
endmodule // lcd_panel_model

// ### testbench/testbench.sv
// self-checking bench for the segment LCD driver
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic [9:0] outs;
	} row_type;
	localparam logic [7:0] SEL = 8'hA5;
	// outs: cap, supply, pump level, pins, source, current
	row_type rows [12] = '{
		'{8'h00, 8'h0B, 8'h0B, 10'h1C0}, '{8'h00, 8'hF6, 8'h02, 10'h080},
		'{8'h01, 8'h40, 8'h40, 10'h2A0}, '{8'h01, 8'h50, 8'h50, 10'h284},
		'{8'h01, 8'h60, 8'h60, 10'h288}, '{8'h01, 8'h78, 8'h70, 10'h290},
		'{8'h01, 8'h06, 8'h06, 10'h083}, '{8'h01, 8'h32, 8'h32, 10'h081},
		'{8'h02, SEL, SEL, 10'h081}, '{8'h03, 8'hFF, 8'h00, 10'h081},
		'{8'h05, 8'hFF, 8'h00, 10'h081}, '{8'h10, 8'h05, 8'h05, 10'h081}};
	logic I_CLOCK = 1'b0;
	logic I_RST = 1'b1;
	logic [7:0] I_ADDR = 8'h00;
	logic [7:0] I_WDATA = 8'h00;
	logic I_WR = 1'b0;
	logic I_RD = 1'b0;
	logic I_SLEEP = 1'b0;
	logic [7:0] O_RDATA, O_COM_LEVEL, O_SEG_DRIVE, lit;
	logic [3:0] O_COM_DRIVE;
	logic [15:0] O_SEG_LEVEL;
	logic O_CAP_BIAS, O_RES_BIAS_ON, O_PUMP_ON, O_SUPPLY_FROM_PUMP;
	logic O_BIAS_FROM_PINS;
	logic [1:0] O_PUMP_LEVEL, O_BIAS_CURRENT;
	logic [2:0] O_INT_SOURCE;
	logic [7:0] mem [8];
	logic [1:0] slot = 2'h0;
	logic phase = 1'b0;
	int errors = 0;
	int checked = 0;
	int n;
	lcd_segment_driver_control i_dut (.I_CLOCK(I_CLOCK), .I_RST(I_RST),
		.I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
		.O_RDATA(O_RDATA), .I_SLEEP(I_SLEEP), .O_COM_LEVEL(O_COM_LEVEL),
		.O_COM_DRIVE(O_COM_DRIVE), .O_SEG_LEVEL(O_SEG_LEVEL),
		.O_SEG_DRIVE(O_SEG_DRIVE), .O_CAP_BIAS(O_CAP_BIAS),
		.O_RES_BIAS_ON(O_RES_BIAS_ON), .O_PUMP_ON(O_PUMP_ON),
		.O_SUPPLY_FROM_PUMP(O_SUPPLY_FROM_PUMP), .O_PUMP_LEVEL(O_PUMP_LEVEL),
		.O_BIAS_FROM_PINS(O_BIAS_FROM_PINS), .O_INT_SOURCE(O_INT_SOURCE),
		.O_BIAS_CURRENT(O_BIAS_CURRENT));
	lcd_panel_model i_panel (.i_com_level(O_COM_LEVEL),
		.i_com_drive(O_COM_DRIVE), .i_seg_level(O_SEG_LEVEL),
		.i_seg_drive(O_SEG_DRIVE), .o_lit(lit));
	initial forever #20 I_CLOCK = ~I_CLOCK;
	task automatic complete_run;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] seen);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge I_CLOCK);
		I_ADDR <= a;
		I_WDATA <= d;
		I_WR <= 1'b1;
		@(posedge I_CLOCK);
		I_WR <= 1'b0;
		@(posedge I_CLOCK);
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge I_CLOCK);
		I_ADDR <= a;
		I_RD <= 1'b1;
		@(posedge I_CLOCK);
		I_RD <= 1'b0;
		#1 check("read data", 16'(exp), 16'(O_RDATA));
		@(posedge I_CLOCK);
		#1 check("read idle", 16'h0000, 16'(O_RDATA));
	endtask
	task automatic check_wave;
		logic [7:0] c;
		logic [15:0] s;
		logic [7:0] l;
		for (int j = 0; j < 4; j++)
			c[2*j+:2] = (j == slot) ? {2{~phase}} : {phase, ~phase};
		for (int i = 0; i < 8; i++) begin
			s[2*i+:2] = SEL[i] ? {mem[i][slot] ^ ~phase, phase} : 2'h0;
			l[i] = SEL[i] & mem[i][slot];
		end
		check("com level", 16'(c), 16'(O_COM_LEVEL));
		check("seg level", s, O_SEG_LEVEL);
		check("lit", 16'(l), 16'(lit));
	endtask
	task automatic wait_tick(output int cnt);
		logic [7:0] was;
		was = O_COM_LEVEL;
		cnt = 0;
		while (O_COM_LEVEL === was && cnt < 7000) begin
			@(posedge I_CLOCK);
			#1;
			cnt++;
		end
		@(posedge I_CLOCK);
		#1;
	endtask
	initial begin
		repeat (60000) @(posedge I_CLOCK);
		errors++;
		complete_run;
	end
	initial begin
		repeat (4) @(posedge I_CLOCK);
		I_RST <= 1'b0;
		check("drive", 16'({O_COM_DRIVE, O_SEG_DRIVE}), 16'h0);
		for (int a = 0; a < 3; a++)
			rd(8'(a), 8'h00);
		$display("test reset done");
		foreach (rows[r]) begin
			wr(rows[r].addr, rows[r].wdata);
			rd(rows[r].addr, rows[r].rdata);
			check("controls", 16'({O_CAP_BIAS, O_SUPPLY_FROM_PUMP,
				O_PUMP_LEVEL, O_BIAS_FROM_PINS, O_INT_SOURCE,
				O_BIAS_CURRENT}), 16'(rows[r].outs));
		end
		$display("test registers done");
		for (int i = 0; i < 8; i++) begin
			mem[i] = 8'(4'(i * 5 + 3));
			wr(8'h10 + 8'(i), mem[i]);
		end
		wr(8'h01, 8'h01);
		check("active", 16'({O_COM_DRIVE, O_SEG_DRIVE}),
			16'({4'hF, SEL}));
		check("bias", 16'({O_RES_BIAS_ON, O_PUMP_ON}), 16'h2);
		check_wave;
		rd(8'h03, 8'h08);
		for (int k = 0; k < 6; k++) begin
			if (k == 2)
				wr(8'h01, 8'h81);
			wait_tick(n);
			if (k == 1)
				check("tick gap", 16'h1867, 16'(n));
			if (k >= 2) begin
				slot++;
				if (slot == 2'h0)
					phase = ~phase;
			end else begin
				phase = ~phase;
				if (!phase)
					slot++;
			end
			check_wave;
		end
		$display("test waveform done");
		@(posedge I_CLOCK);
		I_SLEEP <= 1'b1;
		repeat (2) @(posedge I_CLOCK);
		#1 check("sleep", 16'({O_COM_DRIVE, O_COM_LEVEL}), 16'h0);
		@(posedge I_CLOCK);
		I_SLEEP <= 1'b0;
		repeat (2) @(posedge I_CLOCK);
		#1 slot = 2'h0;
		phase = 1'b0;
		check_wave;
		wr(8'h01, 8'h40);
		check("off", 16'({O_COM_DRIVE, O_PUMP_ON, O_RES_BIAS_ON}),
			16'h0);
		wr(8'h01, 8'h41);
		check("cap", 16'({O_PUMP_ON, O_RES_BIAS_ON}), 16'h2);
		wr(8'h01, 8'h01);
		wr(8'h00, 8'h08);
		check("pump", 16'({O_PUMP_ON, O_SUPPLY_FROM_PUMP}), 16'h3);
		$display("test power done");
		complete_run;
	end
endmodule // testbench
